//--- hw/shbc_defines.svh
// Function
// - Brake code 1: engage immediately on error and at standstill.
// - Brake code 2: engage on error at standstill or 400 ms after error.
// - Brake code 4: engage only when control is off.
// - Holding one: engage on error, and control off at standstill.
// - Holding two: control off at standstill; error at standstill or 400 ms.
// - Holding three: control off at standstill, error immediately, enable loss.
// - Holding four to six: error at standstill window, latest 400 ms.
// - Holding three to six: enable input withdrawn engages brake.
// - Code 9 like holding four, plus torque build-up before release.
// - Holding six: brake closed during commutation finding.
// - Control stays active overlap time after brake on, default 100 ms.
// - Programmable delay before torque reduction after brake engagement.
// - Torque build-up: delay between control on and brake release.
// - Torque build-up: speed reference applied after programmable delay.
// - Torque build-up: pre-control scaled by programmable percentage.
// - Initialized output drops before control init, rises when done.
// - Initialized high after power-on init, independent of enable/start.
// - Ready high only with enable input set and no error.
// - Power-stage-ready high when stage active and commutation done.
// - Four expansion outputs, each with its own function selector.
// - Absent expansion module: selections accepted, outputs held low.
// - Brake code 0: engage at standstill and when control is off.
`ifndef SHBC_DEFINES_SVH
`define SHBC_DEFINES_SVH
// ************************************************************
// Brake type codes
// ************************************************************
`define SHBC_BT_SPD0   4'h0
`define SHBC_BT_ERR1   4'h1
`define SHBC_BT_ERR2   4'h2
`define SHBC_BT_ERR3   4'h3
`define SHBC_BT_HOLD   4'h4
`define SHBC_BT_HOLD_ONE     4'h5
`define SHBC_BT_HOLD_TWO     4'h6
`define SHBC_BT_HOLD_THREE   4'h7
`define SHBC_BT_HOLD_FOUR    4'h8
`define SHBC_BT_HOLD_BUILDUP 4'h9
`define SHBC_BT_HOLD_COMM    4'hA
// ************************************************************
// Timing
// ************************************************************
`define SHBC_CLK_MHZ        250
`define SHBC_MS_CYCLES      (1000 * `SHBC_CLK_MHZ)
`define SHBC_ERR_LIMIT_MS   400
`define SHBC_OVERLAP_DEF_MS 16'h0064
`define SHBC_PCT_FULL       32'h0000_0064
// ************************************************************
// Expansion output function codes
// ************************************************************
`define SHBC_FN_OFF    6'h00
`define SHBC_FN_INIT   6'h13
`define SHBC_FN_READY  6'h14
`define SHBC_FN_SPEED  6'h15
`define SHBC_FN_STAGE  6'h1E
`define SHBC_FN_BRAKE  6'h01
`endif

//--- hw/shbc_pkg.sv
`default_nettype none
package shbc_pkg;
   typedef enum logic [2:0] {
      SHBC_RELEASED,
      SHBC_OVERLAP,
      SHBC_HELD,
      SHBC_BUILDUP
   } shbc_state_e;
endpackage : shbc_pkg
`default_nettype wire

//--- hw/shbc_top.sv
`include "shbc_defines.svh"
`default_nettype none
module shbc_top #(
   parameter int MS_CYCLES = `SHBC_MS_CYCLES,
   parameter int N_EXP     = 4
) (
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   input  wire logic [3:0]        i_brake_type,
   input  wire logic              i_error,
   input  wire logic              i_standstill,
   input  wire logic              i_control_on_req,
   input  wire logic              i_power_stage_enable_in,
   input  wire logic              i_commutation_busy,
   input  wire logic              i_init_busy,
   input  wire logic              i_init_done,
   input  wire logic              i_speed_threshold_reached,
   input  wire logic [15:0]       i_brake_overlap_time,
   input  wire logic [15:0]       i_torque_reduction_delay,
   input  wire logic [15:0]       i_brake_release_delay,
   input  wire logic [15:0]       i_reference_apply_delay,
   input  wire logic [7:0]        i_load_comp_scale,
   input  wire logic [15:0]       i_precontrol_in,
   input  wire logic              i_expansion_present,
   input  wire logic [4*6-1:0]    i_expansion_output_select,
   output logic                   o_brake_engage,
   output logic                   o_control_active,
   output logic                   o_torque_reduce,
   output logic                   o_reference_enable,
   output logic [15:0]            o_precontrol,
   output logic                   o_initialized,
   output logic                   o_ready,
   output logic                   o_stage_ready,
   output logic [N_EXP-1:0]       o_expansion_out
);
   // ************************************************************
   // Input synchronisers
   // ************************************************************
   // Async status inputs pass two flops; stage one feeds only stage two
   localparam int NS = 8;
   logic [NS-1:0] sync1_q;
   logic [NS-1:0] sync2_q;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {i_speed_threshold_reached, i_init_done, i_init_busy, i_commutation_busy,
                     i_power_stage_enable_in, i_control_on_req, i_standstill, i_error};
         sync2_q <= sync1_q;
      end
   end
   logic err, still, ctl_req, pse_in, comm, ibusy, idone, spd;
   assign {spd, idone, ibusy, comm, pse_in, ctl_req, still, err} = sync2_q;

   // ************************************************************
   // Millisecond tick and 400 ms error limit
   // ************************************************************
   logic [31:0] pre_q;
   logic        ms_tick;
   assign ms_tick = (pre_q == 32'(MS_CYCLES - 1));
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) pre_q <= '0;
      else if (ms_tick) pre_q <= '0;
      else pre_q <= pre_q + 32'h0000_0001;
   end

   // Counts ms since error arrived; saturates at the limit
   logic [15:0] err_ms_q;
   logic        err_timeout;
   assign err_timeout = err && (err_ms_q >= 16'(`SHBC_ERR_LIMIT_MS));
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) err_ms_q <= '0;
      else if (!err) err_ms_q <= '0;
      else if (ms_tick && !err_timeout) err_ms_q <= err_ms_q + 16'h0001;
   end

   // ************************************************************
   // Brake-engage term selection
   // ************************************************************
   // Control-off term is the sequencer's own request, not our delayed output
   logic ctl_off, engage_d, is_hold36, err_late;
   assign ctl_off   = !ctl_req;
   assign err_late  = err && (still || err_timeout);
   assign is_hold36 = (i_brake_type >= `SHBC_BT_HOLD_THREE) && (i_brake_type <= `SHBC_BT_HOLD_COMM);
   always_comb begin
      engage_d = 1'b0;
      case (i_brake_type)
         `SHBC_BT_SPD0:  engage_d = still || ctl_off;
         `SHBC_BT_ERR1:  engage_d = err || still;
         `SHBC_BT_ERR2:  engage_d = err_late;
         `SHBC_BT_ERR3:  engage_d = err;
         `SHBC_BT_HOLD:  engage_d = ctl_off;
         `SHBC_BT_HOLD_ONE:     engage_d = err || (ctl_off && still);
         `SHBC_BT_HOLD_TWO:     engage_d = (ctl_off && still) || err_late;
         `SHBC_BT_HOLD_THREE:   engage_d = (ctl_off && still) || err;
         `SHBC_BT_HOLD_FOUR,
         `SHBC_BT_HOLD_BUILDUP: engage_d = (ctl_off && still) || err_late;
         `SHBC_BT_HOLD_COMM:    engage_d = (ctl_off && still) || err_late || comm;
         default:               engage_d = 1'b1;
      endcase
      if (is_hold36 && !pse_in) engage_d = 1'b1;
   end

   // ************************************************************
   // Brake sequencer
   // ************************************************************
   // One ms counter shared by overlap and build-up phases
   shbc_pkg::shbc_state_e st_q;
   logic [15:0] ms_q;
   logic        buildup_mode;
   assign buildup_mode = (i_brake_type == `SHBC_BT_HOLD_BUILDUP);
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_q <= shbc_pkg::SHBC_HELD;
         ms_q <= '0;
      end else begin
         case (st_q)
            shbc_pkg::SHBC_RELEASED: begin
               ms_q <= '0;
               if (engage_d) st_q <= shbc_pkg::SHBC_OVERLAP;
            end
            shbc_pkg::SHBC_OVERLAP: begin
               if (ms_tick) ms_q <= ms_q + 16'h0001;
               if (ms_q >= i_brake_overlap_time) begin
                  st_q <= shbc_pkg::SHBC_HELD;
                  ms_q <= '0;
               end
            end
            shbc_pkg::SHBC_HELD: begin
               ms_q <= '0;
               if (!engage_d && ctl_req)
                  st_q <= buildup_mode ? shbc_pkg::SHBC_BUILDUP : shbc_pkg::SHBC_RELEASED;
            end
            shbc_pkg::SHBC_BUILDUP: begin
               if (ms_tick) ms_q <= ms_q + 16'h0001;
               if (engage_d) st_q <= shbc_pkg::SHBC_HELD;
               else if (ms_q >= i_brake_release_delay) st_q <= shbc_pkg::SHBC_RELEASED;
            end
            default: st_q <= shbc_pkg::SHBC_HELD;
         endcase
      end
   end

   // Brake and control outputs from state
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_brake_engage   <= 1'b1;
         o_control_active <= 1'b0;
      end else begin
         // Build-up keeps the brake shut until the release delay has run
         o_brake_engage   <= (st_q != shbc_pkg::SHBC_RELEASED);
         o_control_active <= (st_q != shbc_pkg::SHBC_HELD);
      end
   end

   // Torque reduction after brake engagement, holding modes only
   logic [15:0] tr_ms_q;
   logic        hold_family;
   assign hold_family = (i_brake_type >= `SHBC_BT_HOLD_ONE) && (i_brake_type <= `SHBC_BT_HOLD_COMM);
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tr_ms_q         <= '0;
         o_torque_reduce <= 1'b0;
      end else if (!o_brake_engage || !hold_family) begin
         tr_ms_q         <= '0;
         o_torque_reduce <= 1'b0;
      end else begin
         if (ms_tick && tr_ms_q != 16'hFFFF) tr_ms_q <= tr_ms_q + 16'h0001;
         o_torque_reduce <= (tr_ms_q >= i_torque_reduction_delay);
      end
   end

   // Reference enable delayed after control active in build-up mode
   logic [15:0] ref_ms_q;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ref_ms_q           <= '0;
         o_reference_enable <= 1'b0;
      end else if (!o_control_active) begin
         ref_ms_q           <= '0;
         o_reference_enable <= 1'b0;
      end else begin
         if (ms_tick && ref_ms_q != 16'hFFFF) ref_ms_q <= ref_ms_q + 16'h0001;
         o_reference_enable <= !buildup_mode || (ref_ms_q >= i_reference_apply_delay);
      end
   end

   // Load compensation: in + in*pct/100, saturating at full scale
   logic [31:0] comp_w;
   assign comp_w = 32'(i_precontrol_in) + (32'(i_precontrol_in) * 32'(i_load_comp_scale)) / `SHBC_PCT_FULL;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) o_precontrol <= '0;
      else if (!buildup_mode) o_precontrol <= i_precontrol_in;
      else o_precontrol <= (comp_w > 32'h0000_FFFF) ? 16'hFFFF : comp_w[15:0];
   end

   // ************************************************************
   // Status outputs
   // ************************************************************
   logic init_n, rdy_n, stg_n;
   assign init_n = idone && !ibusy;
   assign rdy_n  = pse_in && !err;
   assign stg_n  = o_control_active && !comm;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_initialized <= 1'b0;
         o_ready       <= 1'b0;
         o_stage_ready <= 1'b0;
      end else begin
         o_initialized <= init_n;
         o_ready       <= rdy_n;
         o_stage_ready <= stg_n;
      end
   end

   // Expansion outputs; absent module keeps all low
   logic [N_EXP-1:0] exp_d;
   always_comb begin
      for (int k = 0; k < N_EXP; k++) begin
         case (i_expansion_output_select[k*6 +: 6])
            `SHBC_FN_INIT:  exp_d[k] = init_n;
            `SHBC_FN_READY: exp_d[k] = rdy_n;
            `SHBC_FN_SPEED: exp_d[k] = spd;
            `SHBC_FN_STAGE: exp_d[k] = stg_n;
            `SHBC_FN_BRAKE: exp_d[k] = o_brake_engage;
            default:        exp_d[k] = 1'b0;
         endcase
      end
   end
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) o_expansion_out <= '0;
      else o_expansion_out <= i_expansion_present ? exp_d : '0;
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_release;
      st_q == shbc_pkg::SHBC_RELEASED ##1 st_q == shbc_pkg::SHBC_OVERLAP;
   endsequence
   engage_on_error_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_brake_type == `SHBC_BT_ERR1 && err && st_q == shbc_pkg::SHBC_RELEASED) |=> st_q == shbc_pkg::SHBC_OVERLAP)
      else $error("brake not engaged on error");
   err_timeout_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_brake_type == `SHBC_BT_ERR2 && err_timeout) |-> engage_d)
      else $error("error timeout did not engage");
   hold_ctl_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_brake_type == `SHBC_BT_HOLD) |-> (engage_d == ctl_off))
      else $error("control-off term wrong");
   enable_loss_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (is_hold36 && !pse_in) |-> engage_d)
      else $error("enable loss did not engage");
   comm_closed_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_brake_type == `SHBC_BT_HOLD_COMM && comm) |-> engage_d)
      else $error("brake open during commutation");
   overlap_ctl_a: assert property (@(posedge i_clk) disable iff (i_reset)
      s_release |=> o_control_active)
      else $error("control dropped during overlap");
   ready_rel_a: assert property (@(posedge i_clk) disable iff (i_reset)
      o_ready == $past(rdy_n))
      else $error("ready status mismatch");
   stage_rdy_a: assert property (@(posedge i_clk) disable iff (i_reset)
      $past(comm) |-> !o_stage_ready)
      else $error("stage ready during commutation");
   exp_absent_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !$past(i_expansion_present) |-> o_expansion_out == '0)
      else $error("expansion output high while absent");
   // Brake stays closed and control on while the overlap runs
   overlap_brake_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (st_q == shbc_pkg::SHBC_OVERLAP) |=> (o_brake_engage && o_control_active))
      else $error("overlap outputs wrong");
   held_ctl_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (st_q == shbc_pkg::SHBC_HELD) |=> !o_control_active)
      else $error("control active while held");
   // Build-up keeps the brake shut while torque rises
   sequence s_buildup;
      st_q == shbc_pkg::SHBC_HELD ##1 st_q == shbc_pkg::SHBC_BUILDUP;
   endsequence
   buildup_brake_a: assert property (@(posedge i_clk) disable iff (i_reset)
      s_buildup |=> (o_brake_engage && o_control_active))
      else $error("brake opened during build-up");
   // No term set, so the brake must stay open
   stay_released_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (st_q == shbc_pkg::SHBC_RELEASED && !engage_d) |=> st_q == shbc_pkg::SHBC_RELEASED)
      else $error("brake closed without a term");
   err_limit_a: assert property (@(posedge i_clk) disable iff (i_reset)
      err_ms_q <= 16'(`SHBC_ERR_LIMIT_MS))
      else $error("error timer overran the limit");
   torque_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !$past(hold_family) |-> !o_torque_reduce)
      else $error("torque reduced outside holding modes");
   ref_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !$past(o_control_active) |-> !o_reference_enable)
      else $error("reference enabled with control off");
   // Status outputs track their terms one cycle late
   init_status_a: assert property (@(posedge i_clk) disable iff (i_reset)
      o_initialized == $past(init_n))
      else $error("initialized status mismatch");
   stage_status_a: assert property (@(posedge i_clk) disable iff (i_reset)
      o_stage_ready == $past(stg_n))
      else $error("stage ready status mismatch");
   // Reset cycle excluded: the output register was held clear then
   exp_present_a: assert property (@(posedge i_clk) disable iff (i_reset)
      ($past(i_expansion_present) && !$past(i_reset)) |-> o_expansion_out == $past(exp_d))
      else $error("expansion output does not follow selector");
endmodule : shbc_top
`default_nettype wire

//--- tb/shbc_motor_model.sv
`default_nettype none
// ************************************************************
// Motor speed and control sequencer model
// ************************************************************
module shbc_motor_model #(
   parameter int RAMP = 2,
   parameter int INIT = 8
) (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_run,
   input  wire logic i_init_req,
   output logic      o_standstill,
   output logic      o_init_busy,
   output logic      o_init_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int   ramp_q;
   int   init_q;
   logic still_q;
   logic busy_q;
   logic done_q;
   // Speed decays over a short ramp, so standstill lags the stop
   always @(negedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ramp_q  <= RAMP;
         still_q <= 1'h1;
      end else if (i_run) begin
         ramp_q  <= RAMP;
         still_q <= 1'h0;
      end else if (ramp_q != 0) begin
         ramp_q <= ramp_q - 1;
      end else begin
         still_q <= 1'h1;
      end
   end
   // Power-on init runs alone; a request reruns it, done stays set
   always @(negedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         init_q <= INIT;
         busy_q <= 1'h1;
         done_q <= 1'h0;
      end else if (i_init_req) begin
         init_q <= INIT;
         busy_q <= 1'h1;
      end else if (init_q != 0) begin
         init_q <= init_q - 1;
      end else begin
         busy_q <= 1'h0;
         done_q <= 1'h1;
      end
   end
   assign o_standstill = still_q;
   assign o_init_busy  = busy_q;
   assign o_init_done  = done_q;
endmodule : shbc_motor_model
`default_nettype wire

//--- tb/test_servo_holding_brake_control.sv
`default_nettype none
module test_servo_holding_brake_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, err, run, ctrl, pse, comm, spd, pres, ireq, ss, ib, idn;
   logic        brake, cact, tred, refe, init, rdy, srdy;
   logic [3:0]  bt, exo;
   logic [7:0]  pct;
   logic [15:0] ovl, trd, rel, rfd, pin, pco;
   logic [23:0] sel;
   int          num_errors, checks, cycles;
   shbc_top #(.MS_CYCLES(10), .N_EXP(4)) dut (
      .i_clk(clk), .i_reset(rst), .i_brake_type(bt), .i_error(err), .i_standstill(ss),
      .i_control_on_req(ctrl), .i_power_stage_enable_in(pse), .i_commutation_busy(comm),
      .i_init_busy(ib), .i_init_done(idn), .i_speed_threshold_reached(spd),
      .i_brake_overlap_time(ovl), .i_torque_reduction_delay(trd), .i_brake_release_delay(rel),
      .i_reference_apply_delay(rfd), .i_load_comp_scale(pct), .i_precontrol_in(pin),
      .i_expansion_present(pres), .i_expansion_output_select(sel), .o_brake_engage(brake),
      .o_control_active(cact), .o_torque_reduce(tred), .o_reference_enable(refe), .o_precontrol(pco),
      .o_initialized(init), .o_ready(rdy), .o_stage_ready(srdy), .o_expansion_out(exo));
   shbc_motor_model #(.RAMP(2), .INIT(8)) model (
      .i_clk(clk), .i_reset(rst), .i_run(run), .i_init_req(ireq),
      .o_standstill(ss), .o_init_busy(ib), .o_init_done(idn));
   // ************************************************************
   // Clock, timeout and access tasks
   // ************************************************************
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   // Hang guard well above the roughly 15k cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run();
      $display("Checks %0d, errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   // Long enough for overlap, build-up and sync latency to settle
   task automatic go(input logic [3:0] t);
      bt = t;
      err = 1'h0;
      run = 1'h1;
      ctrl = 1'h1;
      pse = 1'h1;
      comm = 1'h0;
      tick(80);
   endtask : go
   task automatic ca(input logic [3:0] t, input logic e, s, c, n, m, x);
      go(t);
      chk(brake, 16'h0000);
      err = e;
      run = !s;
      ctrl = c;
      pse = n;
      comm = m;
      tick(14);
      chk(brake, x);
   endtask : ca
   // Error while turning: brake only once the 400 ms limit expires
   task automatic lim(input logic [3:0] t);
      go(t);
      err = 1'h1;
      tick(3800);
      chk(brake, 16'h0000);
      tick(300);
      chk(brake, 16'h0001);
   endtask : lim
   initial begin
      {rst, err, run, ctrl, pse, comm, spd, pres, ireq} = 9'h100;
      pres = 1'h1;
      {num_errors, checks, cycles} = '0;
      {bt, pct, sel} = {4'h0, 8'h32, 6'h00, 6'h01, 6'h13, 6'h14};
      {ovl, trd, rel, rfd, pin} = {16'h0001, 16'h0003, 16'h0003, 16'h0004, 16'h0100};
      repeat (6) @(posedge clk);
      @(negedge clk) rst = 1'h0;
      tick(30);
      ca(4'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
      ca(4'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
      ca(4'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'h2, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'h2, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
      ca(4'h3, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'h4, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1);
      ca(4'h4, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
      ca(4'h5, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'h5, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
      ca(4'h5, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
      ca(4'h6, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
      ca(4'h6, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
      ca(4'h7, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'h7, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
      ca(4'h8, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
      ca(4'h8, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'h9, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
      ca(4'h9, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1);
      ca(4'hA, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1);
      ca(4'hA, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
      lim(4'h2);
      lim(4'h6);
      lim(4'h8);
      ovl = 16'h0002;
      go(4'h4);
      ctrl = 1'h0;
      tick(12);
      chk(cact, 16'h0001);
      tick(40);
      chk(cact, 16'h0000);
      ovl = 16'h0001;
      go(4'h5);
      err = 1'h1;
      tick(10);
      chk(tred, 16'h0000);
      tick(50);
      chk(tred, 16'h0001);
      go(4'h9);
      {run, ctrl} = 2'h0;
      tick(40);
      ctrl = 1'h1;
      tick(12);
      chk({cact, brake, refe}, 16'h0006);
      tick(60);
      chk({brake, refe}, 16'h0001);
      chk(pco, 16'h0180);
      pin = 16'hFFF0;
      tick(8);
      chk(pco, 16'hFFFF);
      go(4'h5);
      chk({rdy, srdy, exo}, 16'h0033);
      comm = 1'h1;
      err = 1'h1;
      tick(14);
      chk({rdy, srdy, exo}, 16'h0006);
      pres = 1'h0;
      pse = 1'h0;
      tick(8);
      chk({rdy, init, exo}, 16'h0010);
      // Two cycles wide so the model cannot miss the request
      ireq = 1'h1;
      tick(2);
      ireq = 1'h0;
      tick(5);
      chk(init, 16'h0000);
      tick(20);
      chk(init, 16'h0001);
      // Speed and stage-ready selectors, never reached above
      sel = {6'h15, 6'h1E, 6'h01, 6'h00};
      {spd, pres} = 2'h3;
      go(4'h5);
      chk({srdy, exo}, 16'h001C);
      complete_run();
   end
endmodule : test_servo_holding_brake_control
`default_nettype wire
